// [hw/cmcfg_pkg.sv]
package cmcfg_pkg;
   // indexed configuration space (8-bit index port)
   localparam logic [7:0] IDX_PERF_CTRL = 8'h20;
   localparam logic [7:0] IDX_SLAVE_BURST = 8'h41;
   localparam logic [7:0] IDX_SCRATCH_SIZE = 8'hB8;
   localparam logic [7:0] IDX_VIDEO_SMI = 8'hB9;
   localparam logic [7:0] IDX_WIN_SMI_B0 = 8'hBA;
   localparam logic [7:0] IDX_WIN_SMI_B3 = 8'hBD;
   // memory offsets from the module base
   localparam logic [15:0] OFS_REGION_MAP = 16'h8004;
   localparam logic [15:0] OFS_DISP_LO = 16'h8300;
   localparam logic [15:0] OFS_DISP_HI = 16'h830C;
   localparam logic [15:0] OFS_MEM_DRV_ONE = 16'h8400;
   localparam logic [15:0] OFS_MEM_DRV_TWO = 16'h8404;
   // reset values
   localparam logic [7:0] RST_PERF_CTRL = 8'h07;
   localparam logic [7:0] RST_SLAVE_BURST = 8'h00;
   localparam logic [7:0] RST_SCRATCH_SIZE = 8'h00;
   localparam logic [7:0] RST_VIDEO_SMI = 8'h00;
   localparam logic [31:0] RST_WIN_SMI = 32'h00000000;
   localparam logic [31:0] RST_REGION_MAP = 32'h00000000;
   localparam logic [31:0] RST_MEM_DRV_ONE = 32'h248C0040;
   localparam logic [31:0] RST_MEM_DRV_TWO = 32'h00000801;
   localparam logic [31:0] RST_DISP = 32'h00000000;
   // field positions
   localparam int MDATA_DRV_LSB = 30;
   localparam int ADDR_DRV_LSB = 27;
   localparam int CMD_DRV_LSB = 24;
   localparam int XBUS_RR_BIT = 3;
   localparam int SDCLK_DRV_LSB = 12;
   localparam int DISC_BOUND_BIT = 1;
   localparam int SCRATCH_LSB = 2;
   localparam int VID_WRITE_TRAP_BIT = 5;
   localparam int GFX_UPPER_BIT = 28;
   localparam int GFX_MID_BIT = 20;
   localparam int GFX_LOW_BIT = 4;
   localparam int IO_TRAP_LSB = 13;
   localparam int DISP_REGS = 4;

   typedef struct packed {
      logic [7:0] perfCtrl;
      logic [7:0] slaveBurst;
      logic [7:0] scratchSize;
      logic [7:0] videoSmi;
      logic [31:0] winSmi;
      logic [31:0] regionMap;
      logic [31:0] memDrvOne;
      logic [31:0] memDrvTwo;
      logic [DISP_REGS-1:0][31:0] disp;
      logic [7:0] cfgRdData;
      logic [31:0] memRdData;
   } cmcfg_state_t;

   typedef struct packed {
      logic [1:0] dataDrive;
      logic [1:0] addrDrive;
      logic [1:0] cmdDrive;
      logic [1:0] clockDrive;
      logic xbusRoundRobin;
      logic targetDisconnectEn;
      logic [1:0] scratchSize;
      logic videoWriteTrapEn;
      logic [2:0] videoRangeTrapEn;
      logic [31:0] windowTrapEn;
      logic [2:0] gfxRegionEn;
      logic [2:0] ioTrapEn;
   } cmcfg_ctrl_t;
endpackage

// [hw/cmcfg_regs.sv]
// Notes on behaviour
// - data pin drive in bits 31:30
// - address/bank drive in bits 28:27
// - command/strobe/mask drive in bits 25:24
// - target disconnect boundary enable bit
module cmcfg_regs (
   // clock and control
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   // indexed configuration port
   input wire logic cfgWrEn,
   input wire logic cfgRdEn,
   input wire logic [7:0] cfgIndex,
   input wire logic [7:0] cfgWrData,
   output logic [7:0] cfgRdData,
   // memory-mapped port, byte offset from module base
   input wire logic memWrEn,
   input wire logic memRdEn,
   input wire logic [15:0] memOffset,
   input wire logic [3:0] memByteEn,
   input wire logic [31:0] memWrData,
   output logic [31:0] memRdData,
   // decoded settings to the memory controller, bus unit and cache
   output cmcfg_pkg::cmcfg_ctrl_t ctrl
);
   cmcfg_pkg::cmcfg_state_t cur_ff;
   cmcfg_pkg::cmcfg_state_t nxt_cur;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic [1:0] dIdx;
      logic [1:0] wByte;
      dIdx = memOffset[3:2];
      wByte = cfgIndex[1:0] - cmcfg_pkg::IDX_WIN_SMI_B0[1:0];
      nxt_cur = cur_ff;
      // config writes
      if (cfgWrEn) begin
         case (cfgIndex)
            cmcfg_pkg::IDX_PERF_CTRL: nxt_cur.perfCtrl = cfgWrData;
            cmcfg_pkg::IDX_SLAVE_BURST: nxt_cur.slaveBurst = cfgWrData;
            cmcfg_pkg::IDX_SCRATCH_SIZE: nxt_cur.scratchSize = cfgWrData;
            cmcfg_pkg::IDX_VIDEO_SMI: nxt_cur.videoSmi = cfgWrData;
            default: begin
               // the 32-bit window register spans four consecutive indices
               if (cfgIndex >= cmcfg_pkg::IDX_WIN_SMI_B0 &&
                   cfgIndex <= cmcfg_pkg::IDX_WIN_SMI_B3) begin
                  nxt_cur.winSmi[wByte*8 +: 8] = cfgWrData;
               end
            end
         endcase
      end
      // config reads, registered
      if (cfgRdEn) begin
         case (cfgIndex)
            cmcfg_pkg::IDX_PERF_CTRL: nxt_cur.cfgRdData = cur_ff.perfCtrl;
            cmcfg_pkg::IDX_SLAVE_BURST: nxt_cur.cfgRdData = cur_ff.slaveBurst;
            cmcfg_pkg::IDX_SCRATCH_SIZE: nxt_cur.cfgRdData = cur_ff.scratchSize;
            cmcfg_pkg::IDX_VIDEO_SMI: nxt_cur.cfgRdData = cur_ff.videoSmi;
            default: begin
               if (cfgIndex >= cmcfg_pkg::IDX_WIN_SMI_B0 &&
                   cfgIndex <= cmcfg_pkg::IDX_WIN_SMI_B3) begin
                  nxt_cur.cfgRdData = cur_ff.winSmi[wByte*8 +: 8];
               end else begin
                  nxt_cur.cfgRdData = 8'h00;
               end
            end
         endcase
      end
      // memory writes, byte enables honoured
      if (memWrEn) begin
         if (memOffset == cmcfg_pkg::OFS_REGION_MAP) begin
            nxt_cur.regionMap = merge(cur_ff.regionMap, memWrData, memByteEn);
         end else if (memOffset == cmcfg_pkg::OFS_MEM_DRV_ONE) begin
            nxt_cur.memDrvOne = merge(cur_ff.memDrvOne, memWrData, memByteEn);
         end else if (memOffset == cmcfg_pkg::OFS_MEM_DRV_TWO) begin
            nxt_cur.memDrvTwo = merge(cur_ff.memDrvTwo, memWrData, memByteEn);
         end else if (memOffset >= cmcfg_pkg::OFS_DISP_LO &&
                      memOffset <= cmcfg_pkg::OFS_DISP_HI && memOffset[1:0] == 2'h0) begin
            nxt_cur.disp[dIdx] = merge(cur_ff.disp[dIdx], memWrData, memByteEn);
         end
      end
      // memory reads; unmapped offsets read zero
      if (memRdEn) begin
         if (memOffset == cmcfg_pkg::OFS_REGION_MAP) begin
            nxt_cur.memRdData = cur_ff.regionMap;
         end else if (memOffset == cmcfg_pkg::OFS_MEM_DRV_ONE) begin
            nxt_cur.memRdData = cur_ff.memDrvOne;
         end else if (memOffset == cmcfg_pkg::OFS_MEM_DRV_TWO) begin
            nxt_cur.memRdData = cur_ff.memDrvTwo;
         end else if (memOffset >= cmcfg_pkg::OFS_DISP_LO &&
                      memOffset <= cmcfg_pkg::OFS_DISP_HI && memOffset[1:0] == 2'h0) begin
            nxt_cur.memRdData = cur_ff.disp[dIdx];
         end else begin
            nxt_cur.memRdData = 32'h00000000;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge core_clk) begin
      if (reset) begin
         cur_ff.perfCtrl <= cmcfg_pkg::RST_PERF_CTRL;
         cur_ff.slaveBurst <= cmcfg_pkg::RST_SLAVE_BURST;
         cur_ff.scratchSize <= cmcfg_pkg::RST_SCRATCH_SIZE;
         cur_ff.videoSmi <= cmcfg_pkg::RST_VIDEO_SMI;
         cur_ff.winSmi <= cmcfg_pkg::RST_WIN_SMI;
         cur_ff.regionMap <= cmcfg_pkg::RST_REGION_MAP;
         cur_ff.memDrvOne <= cmcfg_pkg::RST_MEM_DRV_ONE;
         cur_ff.memDrvTwo <= cmcfg_pkg::RST_MEM_DRV_TWO;
         cur_ff.disp <= {cmcfg_pkg::DISP_REGS{cmcfg_pkg::RST_DISP}};
         cur_ff.cfgRdData <= 8'h00;
         cur_ff.memRdData <= 32'h00000000;
      end else if (clkEn) begin
         cur_ff <= nxt_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // plain decode; software is trusted to keep the mandatory values, so no
   // field is forced here and a wrong setting stays visible on read-back
   assign cfgRdData = cur_ff.cfgRdData;
   assign memRdData = cur_ff.memRdData;
   assign ctrl.dataDrive = cur_ff.memDrvOne[cmcfg_pkg::MDATA_DRV_LSB +: 2];
   assign ctrl.addrDrive = cur_ff.memDrvOne[cmcfg_pkg::ADDR_DRV_LSB +: 2];
   assign ctrl.cmdDrive = cur_ff.memDrvOne[cmcfg_pkg::CMD_DRV_LSB +: 2];
   assign ctrl.xbusRoundRobin = cur_ff.memDrvOne[cmcfg_pkg::XBUS_RR_BIT];
   assign ctrl.clockDrive = cur_ff.memDrvTwo[cmcfg_pkg::SDCLK_DRV_LSB +: 2];
   assign ctrl.targetDisconnectEn = cur_ff.slaveBurst[cmcfg_pkg::DISC_BOUND_BIT];
   assign ctrl.scratchSize = cur_ff.scratchSize[cmcfg_pkg::SCRATCH_LSB +: 2];
   assign ctrl.videoWriteTrapEn = cur_ff.perfCtrl[cmcfg_pkg::VID_WRITE_TRAP_BIT];
   assign ctrl.videoRangeTrapEn = cur_ff.videoSmi[2:0];
   assign ctrl.windowTrapEn = cur_ff.winSmi;
   assign ctrl.gfxRegionEn = {cur_ff.regionMap[cmcfg_pkg::GFX_UPPER_BIT],
                              cur_ff.regionMap[cmcfg_pkg::GFX_MID_BIT],
                              cur_ff.regionMap[cmcfg_pkg::GFX_LOW_BIT]};
   assign ctrl.ioTrapEn = cur_ff.regionMap[cmcfg_pkg::IO_TRAP_LSB +: 3];
endmodule // cmcfg_regs

// [tb/cmcfg_chk.sv]
module cmcfg_chk (
   // clock, reset and ports of the register block
   input wire logic core_clk,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic cfgWrEn,
   input wire logic cfgRdEn,
   input wire logic [7:0] cfgIndex,
   input wire logic [7:0] cfgWrData,
   input wire logic [7:0] cfgRdData,
   input wire logic memWrEn,
   input wire logic memRdEn,
   input wire logic [15:0] memOffset,
   input wire logic [3:0] memByteEn,
   input wire logic [31:0] memWrData,
   input wire logic [31:0] memRdData,
   input wire cmcfg_pkg::cmcfg_ctrl_t ctrl
);
   timeunit 1ns;
   timeprecision 1ps;
   // write data one cycle late, so a decoded field is tied to what was written
   logic [31:0] wd_ff;
   logic [7:0] cd_ff;
   wire w1 = clkEn && memWrEn && memOffset == 16'h8400;
   wire w2 = clkEn && memWrEn && memOffset == 16'h8404;
   wire w3 = clkEn && memWrEn && memOffset == 16'h8004;
   wire cw = clkEn && cfgWrEn;
   always_ff @(posedge core_clk) begin
      wd_ff <= memWrData;
      cd_ff <= cfgWrData;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////////////////////////
   data_drive_a: assert property (w1 && memByteEn[3] |=> ctrl.dataDrive == wd_ff[31:30])
      else $error("data drive not taken");
   addr_drive_a: assert property (w1 && memByteEn[3] |=> ctrl.addrDrive == wd_ff[28:27])
      else $error("address drive not taken");
   cmd_drive_a: assert property (w1 && memByteEn[3] |=> ctrl.cmdDrive == wd_ff[25:24])
      else $error("command drive not taken");
   clock_drive_a: assert property (w2 && memByteEn[1] |=> ctrl.clockDrive == wd_ff[13:12])
      else $error("clock drive not taken");
   disc_bound_a: assert property (cw && cfgIndex == 8'h41 |=>
      ctrl.targetDisconnectEn == cd_ff[1]) else $error("disconnect enable not taken");
   reset_value_a: assert property ($fell(reset) |-> memRdData == 32'h0
      && cfgRdData == 8'h00 && ctrl.clockDrive == 2'h0 && !ctrl.videoWriteTrapEn)
      else $error("bad reset value");
   rr_bit_a: assert property (w1 && memByteEn[0] |=> ctrl.xbusRoundRobin == wd_ff[3])
      else $error("round robin bit not taken");
   scratch_size_a: assert property (cw && cfgIndex == 8'hB8 |=>
      ctrl.scratchSize == cd_ff[3:2]) else $error("scratchpad size not taken");
   video_trap_a: assert property (cw && cfgIndex == 8'h20 |=>
      ctrl.videoWriteTrapEn == cd_ff[5]) else $error("video write trap not taken");
   range_trap_a: assert property (cw && cfgIndex == 8'hB9 |=>
      ctrl.videoRangeTrapEn == cd_ff[2:0]) else $error("video range traps not taken");
   window_trap_a: assert property (cw && cfgIndex == 8'hBA |=>
      ctrl.windowTrapEn[7:0] == cd_ff) else $error("window trap byte not taken");
   region_map_a: assert property (w3 && memByteEn == 4'hF |=>
      ctrl.gfxRegionEn == {wd_ff[28], wd_ff[20], wd_ff[4]} && ctrl.ioTrapEn == wd_ff[15:13])
      else $error("region map fields not taken");
   freeze_a: assert property (!clkEn |=> $stable(ctrl))
      else $error("settings moved while frozen");
   rd_hold_a: assert property (!(clkEn && memRdEn) |=> $stable(memRdData))
      else $error("read data moved without a read");
   cover property (w1 && memByteEn == 4'hF);
   cover property (!clkEn && memWrEn);
   cover property (clkEn && cfgRdEn && cfgIndex == 8'h41);
endmodule // cmcfg_chk

bind cmcfg_regs cmcfg_chk cmcfg_chk_i (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
   .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgIndex(cfgIndex), .cfgWrData(cfgWrData),
   .cfgRdData(cfgRdData), .memWrEn(memWrEn), .memRdEn(memRdEn), .memOffset(memOffset),
   .memByteEn(memByteEn), .memWrData(memWrData), .memRdData(memRdData), .ctrl(ctrl));

// [tb/cpu_module_cfg_overrides_tb.sv]
module cpu_module_cfg_overrides_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0, reset = 1'b1, clkEn = 1'b1, cfgWrEn = 1'b0, cfgRdEn = 1'b0;
   logic memWrEn = 1'b0, memRdEn = 1'b0;
   logic [7:0] cfgIndex = 8'h00, cfgWrData = 8'h00, cfgRdData;
   logic [15:0] memOffset = 16'h0000;
   logic [3:0] memByteEn = 4'h0, be;
   logic [31:0] memWrData = 32'h0, memRdData, d, e, m1, m2, mk;
   logic [31:0] q[$];
   logic [15:0] ra[18] = '{16'h0020, 16'h0041, 16'h00B8, 16'h00B9, 16'h00BA, 16'h00BB,
      16'h00BC, 16'h00BD, 16'h0055, 16'h8004, 16'h8300, 16'h8304, 16'h8308, 16'h830C,
      16'h8400, 16'h8404, 16'h8000, 16'h8302};
   cmcfg_pkg::cmcfg_ctrl_t ctrl;
   int fail_count = 0, samples_checked = 0, seed = 80;
   cmcfg_regs cmcfg_regs_i (.core_clk(core_clk), .reset(reset), .clkEn(clkEn),
      .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgIndex(cfgIndex), .cfgWrData(cfgWrData),
      .cfgRdData(cfgRdData), .memWrEn(memWrEn), .memRdEn(memRdEn), .memOffset(memOffset),
      .memByteEn(memByteEn), .memWrData(memWrData), .memRdData(memRdData), .ctrl(ctrl));
   initial forever #20 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////////
   // bit 15 of the address picks the memory port, else the index port
   task automatic acc(input bit wr, input logic [15:0] a, input logic [3:0] b,
         input logic [31:0] v);
      @(negedge core_clk);
      cfgWrEn = wr && !a[15];
      cfgRdEn = !wr && !a[15];
      memWrEn = wr && a[15];
      memRdEn = !wr && a[15];
      cfgIndex = a[7:0];
      memOffset = a;
      memByteEn = b;
      cfgWrData = v[7:0];
      memWrData = v;
   endtask
   task automatic rd(input logic [15:0] a, input logic [31:0] x);
      q.push_back(x);
      acc(1'b0, a, 4'h0, 32'h0);
   endtask
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x) begin
         fail_count++;
         $display("CHECK FAILED at %0t: read %h expected %h", $time, g, x);
      end
   endtask
   task automatic final_report;
      // a note left on the queue is a read whose answer never came
      if (q.size() != 0) fail_count++;
      $display("mismatches %0d of %0d compares", fail_count, samples_checked);
      if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // read data is sampled just after the taking edge, while strobes still stand
   initial forever begin
      @(posedge core_clk);
      #1;
      if (!reset && clkEn && (cfgRdEn || memRdEn))
         cmp(cfgRdEn ? {24'h0, cfgRdData} : memRdData, q.pop_front());
   end
   initial begin
      #50000;
      fail_count++;
      final_report();
   end
   initial begin
      repeat (4) @(negedge core_clk);
      reset = 1'b0;
      foreach (ra[k]) begin
         e = ra[k] == 16'h0020 ? 32'h07 : ra[k] == 16'h8400 ? 32'h248C0040 : 32'h0;
         rd(ra[k], ra[k] == 16'h8404 ? 32'h801 : e);
      end
      foreach (ra[k]) if (ra[k][15:8] != 8'h84) acc(1'b1, ra[k], 4'hF, 32'h0);
      m1 = 32'h248C0040;
      m2 = 32'h801;
      repeat (16) begin
         d = $random(seed);
         be = 4'($random(seed));
         d[3] = 1'b1;
         mk = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
         acc(1'b1, 16'h8400, be, d);
         m1 = (m1 & ~mk) | (d & mk);
         rd(16'h8400, m1);
         acc(1'b1, 16'h8404, be, ~d);
         m2 = (m2 & ~mk) | (~d & mk);
         rd(16'h8404, m2);
         acc(1'b1, 16'h0041, 4'h0, d);
         rd(16'h0041, {24'h0, d[7:0]});
         // mandatory fields stay clear while the free bits around them move
         acc(1'b1, 16'h0020, 4'h0, d & 32'hDF);
         rd(16'h0020, {24'h0, d[7:0] & 8'hDF});
         acc(1'b1, 16'h00B8, 4'h0, d & 32'hF3);
         rd(16'h00B8, {24'h0, d[7:0] & 8'hF3});
         acc(1'b1, 16'h00B9, 4'h0, d & 32'hF8);
         rd(16'h00B9, {24'h0, d[7:0] & 8'hF8});
         e = d & ~32'h1010E010;
         acc(1'b1, 16'h8004, 4'hF, e);
         rd(16'h8004, e);
         acc(1'b1, 16'h8000, 4'hF, d);
         rd(16'h8000, 32'h0);
      end
      @(negedge core_clk);
      clkEn = 1'b0;
      acc(1'b1, 16'h8400, 4'hF, ~m1);
      rd(16'h8400, m1);
      clkEn = 1'b1;
      @(negedge core_clk);
      {cfgWrEn, cfgRdEn, memWrEn, memRdEn} = 4'h0;
      repeat (3) @(posedge core_clk);
      final_report();
   end
endmodule // cpu_module_cfg_overrides_tb
